// File: core/i2csr_consts.svh
/*
  Constants for the two-wire register access slave: bus address, last
  bit index, table memory window and filter length.
  Assumes inclusion by bare name from the core files.
*/
`ifndef I2CSR_CONSTS_SVH
`define I2CSR_CONSTS_SVH

`define I2CSR_DEV_ADDR 7'h47
`define I2CSR_FILT_LEN 3
`define I2CSR_TBL_MASK 16'hF000
`define I2CSR_TBL_BASE 16'hF000
`define I2CSR_BIT_LAST 3'h7

`endif

// File: core/i2csr_pkg.sv
/*
  Types shared by the two-wire register access slave.
  Assumes the constants header is compiled alongside.
*/
package i2csr_pkg;

  // Register write handed to the internal register interface
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
  } i2csr_wr_t;

  // Protocol phase of the slave
  typedef enum logic [2:0] {
    I2CSR_IDLE = 3'h0,
    I2CSR_ADDR = 3'h1,
    I2CSR_RECV = 3'h2,
    I2CSR_SEND = 3'h3,
    I2CSR_IGN = 3'h4
  } i2csr_state_t;

endpackage

// File: core/i2csr_sync.sv
/*
  Two-flop synchroniser followed by a glitch filter that counts consecutive differing samples.
  Assumes the input is asynchronous to CLK_I.
*/
`include "i2csr_consts.svh"

module i2csr_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic level_o
);

  logic meta_r;
  logic sync_r;
  logic [1:0] cnt_r;

  // --------------------------------------------------------------
  // Synchroniser
  // --------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
    end
  end

  // --------------------------------------------------------------
  // Filter
  // --------------------------------------------------------------
  // Output follows only after the input held steady for the filter length
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 2'h0;
      level_o <= 1'b1;
    end else if (sync_r == level_o) begin
      cnt_r <= 2'h0;
    end else if (cnt_r == 2'(`I2CSR_FILT_LEN - 1)) begin
      cnt_r <= 2'h0;
      level_o <= sync_r;
    end else begin
      cnt_r <= cnt_r + 2'h1;
    end
  end

endmodule

// File: core/i2csr_byte_order.sv
/*
  Selects which half of a 16-bit word travels first on the bus.
  Assumes the swap select is a steady level from the same clock.
*/
module i2csr_byte_order (
  input wire logic swap_i,
  input wire logic [15:0] word_i,
  output logic [15:0] word_o
);

  // Swap: low byte goes first when set
  assign word_o = swap_i ? {word_i[7:0], word_i[15:8]} : word_i;

endmodule

// File: core/i2csr_slave.sv
/*
  Two-wire bus register access slave (target only).
  Assumes SCL_I and SDA_I are raw pin levels, the register read
  interface answers RD_DATA_I within one clock of RD_REQ_O, and
  the pad resolves the open-drain wire from SDA_OE_N_O.
*/
// What this block does
// - Target only; never drives clock or conditions
// - Data line only pulled low or released
// - Answers only its fixed seven-bit address
// - Data line changes only while clock low
// - Start and stop seen while clock high
// - Address byte: seven bits plus direction
// - Acknowledge matching address on ninth clock
// - Two bytes after write header set pointer
// - Every register access moves two bytes
// - Pointer advances per word until stop
// - Table memory space keeps pointer fixed
// - After stop return idle, await start
// - Byte order of words is selectable
`include "i2csr_consts.svh"

module i2csr_slave (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  input wire logic SWAP_I,
  input wire logic [15:0] RD_DATA_I,
  output logic SDA_O,
  output logic SDA_OE_N_O,
  output logic WR_VALID_O,
  output i2csr_pkg::i2csr_wr_t WR_O,
  output logic RD_REQ_O,
  output logic [15:0] RD_ADDR_O,
  output logic BUSY_O
);

  // --------------------------------------------------------------
  // Input conditioning
  // --------------------------------------------------------------
  logic scl_f;
  logic sda_f;
  logic scl_d_r;
  logic sda_d_r;

  // Both lines pass two flops and a filter before any edge logic
  i2csr_sync u_scl_sync (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .pin_i(SCL_I),
    .level_o(scl_f)
  );
  i2csr_sync u_sda_sync (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .pin_i(SDA_I),
    .level_o(sda_f)
  );

  // Delayed copies for edge detection
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_f;
      sda_d_r <= sda_f;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // Conditions are data edges while clock stays high
  assign scl_rise = scl_f & ~scl_d_r;
  assign scl_fall = ~scl_f & scl_d_r;
  assign start_det = scl_f & scl_d_r & sda_d_r & ~sda_f;
  assign stop_det = scl_f & scl_d_r & ~sda_d_r & sda_f;

  // --------------------------------------------------------------
  // Protocol state
  // --------------------------------------------------------------
  i2csr_pkg::i2csr_state_t state_r;
  logic [2:0] bit_r;
  logic [7:0] shift_r;
  logic ack_phase_r;
  logic byte_hi_r;
  logic [1:0] ptr_cnt_r;
  logic [15:0] ptr_r;
  logic fixed_r;
  logic [7:0] hold_r;
  logic [15:0] tx_word_r;
  logic master_ack_r;
  logic [15:0] rx_word;
  logic [15:0] tx_word;
  logic [7:0] rx_byte;
  logic addr_match;
  logic addr_match_r;
  logic read_ack_slot;

  assign rx_byte = {shift_r[6:0], sda_f};
  assign addr_match = (rx_byte[7:1] == `I2CSR_DEV_ADDR);
  assign read_ack_slot = ack_phase_r;

  // Byte order applies to both directions
  i2csr_byte_order u_rx_order (
    .swap_i(SWAP_I),
    .word_i({hold_r, rx_byte}),
    .word_o(rx_word)
  );
  i2csr_byte_order u_tx_order (
    .swap_i(SWAP_I),
    .word_i(RD_DATA_I),
    .word_o(tx_word)
  );

  // Bit counter and shifter, sampled on clock rise; the master
  // owns every clock edge, we only follow it
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      bit_r <= 3'h0;
      shift_r <= 8'h00;
      ack_phase_r <= 1'b0;
    end else if (start_det || stop_det) begin
      bit_r <= 3'h0;
      ack_phase_r <= 1'b0;
    end else if (scl_rise) begin
      if (ack_phase_r) begin
        ack_phase_r <= 1'b0;
        bit_r <= 3'h0;
      end else begin
        shift_r <= rx_byte;
        bit_r <= bit_r + 3'h1;
        ack_phase_r <= (bit_r == `I2CSR_BIT_LAST);
      end
    end
  end

  logic byte_done;
  assign byte_done = scl_rise & ~ack_phase_r & (bit_r == `I2CSR_BIT_LAST);

  // Phase machine
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_r <= i2csr_pkg::I2CSR_IDLE;
    end else if (stop_det) begin
      state_r <= i2csr_pkg::I2CSR_IDLE;
    end else if (start_det) begin
      state_r <= i2csr_pkg::I2CSR_ADDR;
    end else if (scl_rise && ack_phase_r && state_r == i2csr_pkg::I2CSR_SEND
                 && master_ack_r) begin
      state_r <= i2csr_pkg::I2CSR_IGN; // Master NACK ends the read
    end else if (byte_done) begin
      unique case (state_r)
        i2csr_pkg::I2CSR_ADDR: begin
          if (!addr_match) begin
            state_r <= i2csr_pkg::I2CSR_IGN;
          end else if (rx_byte[0]) begin
            state_r <= i2csr_pkg::I2CSR_SEND;
          end else begin
            state_r <= i2csr_pkg::I2CSR_RECV;
          end
        end
        i2csr_pkg::I2CSR_IDLE,
        i2csr_pkg::I2CSR_RECV,
        i2csr_pkg::I2CSR_SEND,
        i2csr_pkg::I2CSR_IGN: begin
          state_r <= state_r;
        end
        default: begin
          state_r <= i2csr_pkg::I2CSR_IDLE;
        end
      endcase
    end
  end

  // Data line registered every clock; read as master acknowledge at the ack clock rise of a read byte
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      master_ack_r <= 1'b0;
    end else begin
      master_ack_r <= sda_f;
    end
  end

  // --------------------------------------------------------------
  // Pointer and word assembly
  // --------------------------------------------------------------
  // Pointer bytes count from each write header; data from then on
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ptr_cnt_r <= 2'h0;
      ptr_r <= 16'h0000;
      fixed_r <= 1'b0;
      byte_hi_r <= 1'b0;
      hold_r <= 8'h00;
    end else if (stop_det) begin
      ptr_cnt_r <= 2'h0;
      byte_hi_r <= 1'b0;
    end else if (start_det) begin
      byte_hi_r <= 1'b0; // Repeated start keeps the pointer
    end else if (byte_done && state_r == i2csr_pkg::I2CSR_ADDR && addr_match
                 && !rx_byte[0]) begin
      ptr_cnt_r <= 2'h0;
    end else if (byte_done && state_r == i2csr_pkg::I2CSR_RECV) begin
      if (ptr_cnt_r == 2'h0) begin
        ptr_r[15:8] <= rx_byte;
        ptr_cnt_r <= 2'h1;
      end else if (ptr_cnt_r == 2'h1) begin
        ptr_r[7:0] <= rx_byte;
        fixed_r <= (({ptr_r[15:8], rx_byte} & `I2CSR_TBL_MASK) == `I2CSR_TBL_BASE);
        ptr_cnt_r <= 2'h2;
      end else if (!byte_hi_r) begin
        hold_r <= rx_byte;
        byte_hi_r <= 1'b1;
      end else begin
        byte_hi_r <= 1'b0;
        if (!fixed_r) begin
          ptr_r <= ptr_r + 16'h0001;
        end
      end
    end else if (byte_done && state_r == i2csr_pkg::I2CSR_SEND) begin
      byte_hi_r <= ~byte_hi_r;
      if (byte_hi_r && !fixed_r) begin
        ptr_r <= ptr_r + 16'h0001;
      end
    end
  end

  // Write word strobe, one cycle, after the second data byte
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      WR_VALID_O <= 1'b0;
      WR_O <= '0;
    end else begin
      WR_VALID_O <= 1'b0;
      if (byte_done && state_r == i2csr_pkg::I2CSR_RECV && ptr_cnt_r == 2'h2
          && byte_hi_r && !start_det && !stop_det) begin
        WR_VALID_O <= 1'b1;
        WR_O.addr <= ptr_r;
        WR_O.data <= rx_word;
      end
    end
  end

  // Read request at the start of each word; data taken one cycle later
  logic rd_pend_r;
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      RD_REQ_O <= 1'b0;
      RD_ADDR_O <= 16'h0000;
      rd_pend_r <= 1'b0;
      tx_word_r <= 16'h0000;
    end else begin
      RD_REQ_O <= 1'b0;
      rd_pend_r <= RD_REQ_O;
      if (rd_pend_r) begin
        tx_word_r <= tx_word;
      end
      if (byte_done && state_r == i2csr_pkg::I2CSR_ADDR && addr_match && rx_byte[0]) begin
        RD_REQ_O <= 1'b1;
        RD_ADDR_O <= ptr_r;
      end else if (scl_rise && ack_phase_r && state_r == i2csr_pkg::I2CSR_SEND
                   && !sda_f && byte_hi_r == 1'b0 && !addr_match_r) begin
        // Header acknowledge is our own pull; the first word was already
        // requested at the header, so asking again would repeat it
        RD_REQ_O <= 1'b1;
        RD_ADDR_O <= ptr_r;
      end
    end
  end

  // --------------------------------------------------------------
  // Data line driver
  // --------------------------------------------------------------
  // Set and released on clock fall, and also released on start or stop, so the line is steady while clock high;
  // we only ever pull low or release
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      SDA_O <= 1'b0;
      SDA_OE_N_O <= 1'b1;
    end else if (start_det || stop_det) begin
      SDA_OE_N_O <= 1'b1;
    end else if (scl_fall) begin
      SDA_O <= 1'b0;
      SDA_OE_N_O <= 1'b1;
      if (ack_phase_r) begin
        // The phase has moved on by this fall, so the header
        // acknowledge keys off the held match, not the state
        if (addr_match_r || state_r == i2csr_pkg::I2CSR_RECV) begin
          SDA_OE_N_O <= 1'b0;
        end
      end else if (state_r == i2csr_pkg::I2CSR_SEND && !read_ack_slot) begin
        // Pull low for a zero bit, release for a one
        SDA_OE_N_O <= (byte_hi_r ? tx_word_r[3'h7 - bit_r] : tx_word_r[4'hF - {1'b0, bit_r}]);
      end
    end
  end

  // Address match held from the address byte until the next byte completes
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      addr_match_r <= 1'b0;
    end else if (byte_done) begin
      addr_match_r <= (state_r == i2csr_pkg::I2CSR_ADDR) && addr_match;
    end
  end

  // Busy between a start and the stop that frees the bus
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      BUSY_O <= 1'b0;
    end else if (stop_det) begin
      BUSY_O <= 1'b0;
    end else if (start_det) begin
      BUSY_O <= 1'b1;
    end
  end

endmodule

// File: testbench/i2csr_slave_properties.sv
/*
  Checker for the two-wire register access slave, bound to its ports.
  Assumes the data pin port carries the resolved open-drain wire level.
*/
`include "i2csr_consts.svh"

module i2csr_slave_properties (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_N_O,
  input wire logic WR_VALID_O,
  input wire i2csr_pkg::i2csr_wr_t WR_O,
  input wire logic RD_REQ_O,
  input wire logic [15:0] RD_ADDR_O,
  input wire logic BUSY_O
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  logic have_r;
  logic [15:0] last_r;
  logic acc;
  logic [15:0] acc_addr;
  // --------------------
  // Pointer tracking
  // --------------------
  // A new header may reload the pointer, so tracking restarts on any start
  assign acc = WR_VALID_O | RD_REQ_O;
  assign acc_addr = WR_VALID_O ? WR_O.addr : RD_ADDR_O;
  always_ff @(posedge CLK_I) begin
    if (RST_I || !BUSY_O || (SCL_I && $fell(SDA_I))) have_r <= 1'b0;
    else if (acc) have_r <= 1'b1;
  end
  always_ff @(posedge CLK_I) begin
    if (acc) last_r <= acc_addr;
  end
  // --------------------
  // Properties
  // --------------------
  a_drive_low: assert property (SDA_O == 1'b0)
    else $error("data pin driven high");
  a_oe_scl_low: assert property ($changed(SDA_OE_N_O) |-> !SCL_I)
    else $error("data enable moved while clock high");
  a_idle_release: assert property (!BUSY_O |-> SDA_OE_N_O)
    else $error("data pulled while bus free");
  a_wr_pulse: assert property (WR_VALID_O |=> !WR_VALID_O)
    else $error("write strobe longer than one cycle");
  a_rd_pulse: assert property (RD_REQ_O |=> !RD_REQ_O)
    else $error("read strobe longer than one cycle");
  a_access_busy: assert property (acc |-> BUSY_O)
    else $error("register access outside transaction");
  a_start_seen: assert property (!BUSY_O && SCL_I && $fell(SDA_I) |-> ##[2:12] BUSY_O)
    else $error("start not detected");
  a_stop_seen: assert property (BUSY_O && SCL_I && $past(SCL_I) && $rose(SDA_I)
    |-> ##[2:12] !BUSY_O)
    else $error("stop not detected");
  a_ack_hold: assert property ($fell(SDA_OE_N_O) |=> !SDA_OE_N_O [*8])
    else $error("pull released too early");
  a_ptr_step: assert property (acc && have_r |-> acc_addr ==
    (((last_r & `I2CSR_TBL_MASK) == `I2CSR_TBL_BASE) ? last_r : last_r + 16'h0001))
    else $error("pointer step wrong");
endmodule

bind i2csr_slave i2csr_slave_properties u_props (.CLK_I(CLK_I), .RST_I(RST_I), .SCL_I(SCL_I),
  .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_N_O(SDA_OE_N_O), .WR_VALID_O(WR_VALID_O),
  .WR_O(WR_O), .RD_REQ_O(RD_REQ_O), .RD_ADDR_O(RD_ADDR_O), .BUSY_O(BUSY_O));

// File: testbench/i2csr_host_model.sv
/*
  Two-wire bus master model: makes the clock and its own data pull.
  Assumes the bench ANDs all pulls into the wire fed back on sda_i.
*/
module i2csr_host_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------
  // Bus timing
  // --------------------
  // Quarter bit of 6 clocks: the slave's filter delay must fit in a low phase
  task automatic q();
    repeat (6) @(posedge clk_i);
  endtask
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // One bit: data set mid low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    q();
    sda_o <= b;
    q();
    scl_o <= 1'b1;
    q();
    r = sda_i;
    q();
    scl_o <= 1'b0;
  endtask
  task automatic start();
    q();
    sda_o <= 1'b1;
    q();
    scl_o <= 1'b1;
    q();
    sda_o <= 1'b0;
    q();
    scl_o <= 1'b0;
  endtask
  task automatic stop();
    q();
    sda_o <= 1'b0;
    q();
    scl_o <= 1'b1;
    q();
    sda_o <= 1'b1;
    q();
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rd_byte(input logic ack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(!ack, r);
  endtask
endmodule

// File: testbench/tb_i2csr_slave.sv
/*
  Self-checking bench for the two-wire register access slave.
  Assumes a 10 MHz clock and a behavioural register file answering reads.
*/
module tb_i2csr_slave;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, swap, scl, sda_m, sda_drv, sda_oe_n, wr_valid, rd_req, busy;
  logic [15:0] rd_data, rd_addr;
  i2csr_pkg::i2csr_wr_t wr;
  i2csr_pkg::i2csr_wr_t wq[$];
  logic [15:0] aq[$];
  int fail_count, tests_run;
  // Open-drain wire: low if either party pulls
  wire sda = sda_m & (sda_oe_n | sda_drv);
  i2csr_slave uut (.CLK_I(clk), .RST_I(rst), .SCL_I(scl), .SDA_I(sda), .SWAP_I(swap),
    .RD_DATA_I(rd_data), .SDA_O(sda_drv), .SDA_OE_N_O(sda_oe_n), .WR_VALID_O(wr_valid),
    .WR_O(wr), .RD_REQ_O(rd_req), .RD_ADDR_O(rd_addr), .BUSY_O(busy));
  i2csr_host_model host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(sda_m));
  // --------------------
  // Register side model
  // --------------------
  always @(posedge clk) begin
    if (rst) begin
      rd_data <= 16'h0000;
    end else begin
      if (wr_valid) wq.push_back(wr);
      if (rd_req) begin
        aq.push_back(rd_addr);
        rd_data <= rd_addr ^ 16'hA5C3;
      end
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic stop_idle();
    int n;
    host.stop();
    n = 0;
    while (busy !== 1'b0) begin
      @(posedge clk);
      n++;
      if (n > 50) begin
        fail_count++;
        end_sim();
      end
    end
  endtask
  task automatic hdr(input logic [15:0] ptr);
    logic a;
    host.start();
    host.wr_byte(8'h8E, a);
    chk(32'(a), 32'h1);
    host.wr_byte(ptr[15:8], a);
    chk(32'(a), 32'h1);
    host.wr_byte(ptr[7:0], a);
    chk(32'(a), 32'h1);
  endtask
  task automatic wr_word(input logic [15:0] w);
    logic a;
    host.wr_byte(w[15:8], a);
    chk(32'(a), 32'h1);
    host.wr_byte(w[7:0], a);
    chk(32'(a), 32'h1);
  endtask
  // --------------------
  // Scenarios
  // --------------------
  // Pointer increment across a low byte carry
  task automatic t_write();
    wq.delete();
    hdr(16'h12FF);
    wr_word(16'hA55A);
    wr_word(16'h0180);
    stop_idle();
    chk(32'(wq.size()), 32'h2);
    chk(wq[0], {16'h12FF, 16'hA55A});
    chk(wq[1], {16'h1300, 16'h0180});
    $display("write test done");
  endtask
  // Table space holds the pointer; swapped byte order on the bus
  task automatic t_table();
    wq.delete();
    swap <= 1'b1;
    hdr(16'hF0F0);
    wr_word(16'h1234);
    wr_word(16'h5678);
    stop_idle();
    swap <= 1'b0;
    chk(32'(wq.size()), 32'h2);
    chk(wq[0], {16'hF0F0, 16'h3412});
    chk(wq[1], {16'hF0F0, 16'h7856});
    $display("table test done");
  endtask
  // Pointer write, repeated start, two words read, last byte refused
  task automatic t_read();
    logic a;
    logic [7:0] b0, b1, b2, b3;
    wq.delete();
    aq.delete();
    hdr(16'h00FE);
    host.start();
    host.wr_byte(8'h8F, a);
    chk(32'(a), 32'h1);
    host.rd_byte(1'b1, b0);
    host.rd_byte(1'b1, b1);
    host.rd_byte(1'b1, b2);
    host.rd_byte(1'b0, b3);
    stop_idle();
    chk({b0, b1, b2, b3}, 32'hA53DA53C);
    chk(32'(aq.size()), 32'h2);
    chk({aq[0], aq[1]}, 32'h00FE00FF);
    chk(32'(wq.size()), 32'h0);
    $display("read test done");
  endtask
  // Swapped read from table space: low byte first, address held
  task automatic t_read_swap();
    logic a;
    logic [7:0] b0, b1, b2, b3;
    aq.delete();
    swap <= 1'b1;
    hdr(16'hF010);
    host.start();
    host.wr_byte(8'h8F, a);
    chk(32'(a), 32'h1);
    host.rd_byte(1'b1, b0);
    host.rd_byte(1'b1, b1);
    host.rd_byte(1'b1, b2);
    host.rd_byte(1'b0, b3);
    stop_idle();
    swap <= 1'b0;
    chk({b0, b1, b2, b3}, 32'hD355D355);
    chk(32'(aq.size()), 32'h2);
    chk({aq[0], aq[1]}, 32'hF010F010);
    $display("swapped read test done");
  endtask
  // Foreign address ignored, then a fresh write after stop; odd byte dropped
  task automatic t_foreign();
    logic a;
    wq.delete();
    host.start();
    host.wr_byte(8'h90, a);
    chk(32'(a), 32'h0);
    host.wr_byte(8'h8E, a);
    chk(32'(a), 32'h0);
    stop_idle();
    hdr(16'h0005);
    wr_word(16'hBEEF);
    host.wr_byte(8'h77, a);
    stop_idle();
    chk(32'(wq.size()), 32'h1);
    chk(wq[0], {16'h0005, 16'hBEEF});
    $display("foreign test done");
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    swap = 1'b0;
    fail_count = 0;
    tests_run = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_write();
    t_table();
    t_read();
    t_read_swap();
    t_foreign();
    end_sim();
  end
endmodule
